// file: design/pmw_port_cfg.sv
// port mode and wake configuration for the four 4-bit i/o ports
`timescale 1ns/1ps
module pmw_port_cfg
    import pmw_pkg::*;
#(
    parameter int WIDTH = PMW_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // immediate-load port from the instruction decoder
    input wire logic cfg_wr,
    input wire pmw_sel_t cfg_sel,
    input wire logic [WIDTH-1:0] cfg_data,
    // interrupt enable flag held by the interrupt controller
    input wire logic port_c_change_irq_enable,
    // core output latches for the driven ports
    input wire logic [WIDTH-1:0] port_a_out_data,
    input wire logic [WIDTH-1:0] port_b_out_data,
    // pins
    input wire logic [WIDTH-1:0] port_a_pin_in,
    input wire logic [WIDTH-1:0] port_b_pin_in,
    input wire logic [WIDTH-1:0] port_c_pin_in,
    output logic [WIDTH-1:0] port_a_pin_out,
    output logic [WIDTH-1:0] port_a_pin_oe_n,
    output logic [WIDTH-1:0] port_b_pin_out,
    output logic [WIDTH-1:0] port_b_pin_oe_n,
    output logic port_c_pullup_en,
    output logic port_d_pullup_en,
    // synchronised pin levels for the core to read
    output logic [WIDTH-1:0] port_a_in_data,
    output logic [WIDTH-1:0] port_b_in_data,
    output logic [WIDTH-1:0] port_c_in_data,
    // events
    output logic hold_release,
    output logic port_c_change_irq
);
    // configuration registers, write-only from software
    logic [WIDTH-1:0] change_wake_mask_reg;
    logic [WIDTH-1:0] change_wake_mask_next;
    logic [WIDTH-1:0] port_drive_pull_cfg_reg;
    logic [WIDTH-1:0] port_drive_pull_cfg_next;
    logic [WIDTH-1:0] port_a_dir_cfg_reg;
    logic [WIDTH-1:0] port_a_dir_cfg_next;
    logic [WIDTH-1:0] port_b_dir_cfg_reg;
    logic [WIDTH-1:0] port_b_dir_cfg_next;

    // pull-up outputs registered separately
    logic c_pullup_reg;
    logic c_pullup_next;
    logic d_pullup_reg;
    logic d_pullup_next;

    // synchronised pins and previous port_c sample
    logic [WIDTH-1:0] a_sync;
    logic [WIDTH-1:0] b_sync;
    logic [WIDTH-1:0] c_sync;
    logic [WIDTH-1:0] c_prev_reg;
    logic [WIDTH-1:0] c_prev_next;

    // fill marks, one per flop between the pin and the compare; a change is
    // trusted only once the synchroniser and the previous sample hold pin levels,
    // otherwise a pin that idles high would look like an edge right after reset
    logic [2:0] c_fill_reg;
    logic [2:0] c_fill_next;
    // compare-is-trusted flag, taken from the last fill mark
    logic c_primed;

    // event pulses
    logic hold_release_reg;
    logic hold_release_next;
    logic change_irq_reg;
    logic change_irq_next;

    // input data registers
    logic [WIDTH-1:0] a_in_reg;
    logic [WIDTH-1:0] b_in_reg;
    logic [WIDTH-1:0] c_in_reg;
    logic [WIDTH-1:0] a_in_next;
    logic [WIDTH-1:0] b_in_next;
    logic [WIDTH-1:0] c_in_next;

    // masked change vector
    logic [WIDTH-1:0] c_change;

    // the register fields are fixed at four bits
    initial begin
        if (WIDTH != PMW_W) $error("pmw_port_cfg: WIDTH must equal 4");
    end

    // pin synchronisers, two flops before any logic
    pmw_sync #(.WIDTH(WIDTH)) u_sync_a (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .async_in(port_a_pin_in),
        .sync_out(a_sync)
    );
    pmw_sync #(.WIDTH(WIDTH)) u_sync_b (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .async_in(port_b_pin_in),
        .sync_out(b_sync)
    );
    pmw_sync #(.WIDTH(WIDTH)) u_sync_c (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .async_in(port_c_pin_in),
        .sync_out(c_sync)
    );

    // configuration register writes
    always_comb begin
        change_wake_mask_next = change_wake_mask_reg;
        port_drive_pull_cfg_next = port_drive_pull_cfg_reg;
        port_a_dir_cfg_next = port_a_dir_cfg_reg;
        port_b_dir_cfg_next = port_b_dir_cfg_reg;
        // a write lands only on an enabled cycle with the strobe up
        if (clk_en && cfg_wr) begin
            case (cfg_sel)
                PMW_SEL_WAKE_MASK: begin
                    change_wake_mask_next = cfg_data;
                end
                PMW_SEL_DRIVE_PULL: begin
                    port_drive_pull_cfg_next = cfg_data;
                end
                PMW_SEL_A_DIR: begin
                    port_a_dir_cfg_next = cfg_data;
                end
                PMW_SEL_B_DIR: begin
                    port_b_dir_cfg_next = cfg_data;
                end
                default: begin
                    // all four codes are decoded; nothing changes here
                    change_wake_mask_next = change_wake_mask_reg;
                end
            endcase
        end
    end

    // configuration registers; direction resets to all inputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            change_wake_mask_reg <= PMW_WAKE_MASK_RST;
            port_drive_pull_cfg_reg <= PMW_DRIVE_PULL_RST;
            port_a_dir_cfg_reg <= PMW_A_DIR_RST;
            port_b_dir_cfg_reg <= PMW_B_DIR_RST;
        end else begin
            // write-only: no read path, the core never sees these back
            change_wake_mask_reg <= change_wake_mask_next;
            port_drive_pull_cfg_reg <= port_drive_pull_cfg_next;
            port_a_dir_cfg_reg <= port_a_dir_cfg_next;
            port_b_dir_cfg_reg <= port_b_dir_cfg_next;
        end
    end

    // port_a and port_b pin drivers, output type from the drive/pull field
    pmw_pin_drive #(.WIDTH(WIDTH)) u_drive_a (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .dir_in_mode(port_a_dir_cfg_reg),
        .open_drain(port_drive_pull_cfg_reg[PMW_DP_A_OPEN_DRAIN]),
        .out_data(port_a_out_data),
        .pin_out(port_a_pin_out),
        .pin_oe_n(port_a_pin_oe_n)
    );
    pmw_pin_drive #(.WIDTH(WIDTH)) u_drive_b (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .dir_in_mode(port_b_dir_cfg_reg),
        .open_drain(port_drive_pull_cfg_reg[PMW_DP_B_OPEN_DRAIN]),
        .out_data(port_b_out_data),
        .pin_out(port_b_pin_out),
        .pin_oe_n(port_b_pin_oe_n)
    );

    // pull-up enables follow the drive/pull field
    always_comb begin
        c_pullup_next = c_pullup_reg;
        d_pullup_next = d_pullup_reg;
        // one flop after the register, so the pins come straight from flops
        if (clk_en) begin
            c_pullup_next = port_drive_pull_cfg_reg[PMW_DP_C_PULLUP];
            d_pullup_next = port_drive_pull_cfg_reg[PMW_DP_D_PULLUP];
        end
    end

    // pull-up registers, off after reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            c_pullup_reg <= 1'b0;
            d_pullup_reg <= 1'b0;
        end else begin
            c_pullup_reg <= c_pullup_next;
            d_pullup_reg <= d_pullup_next;
        end
    end

    // change detection compares synced sample with the one before
    assign c_change = (c_sync ^ c_prev_reg) & change_wake_mask_reg;

    // compare is trusted only after three enabled edges since reset
    assign c_primed = c_fill_reg[2];

    // previous sample and fill marks
    always_comb begin
        c_prev_next = c_prev_reg;
        c_fill_next = c_fill_reg;
        if (clk_en) begin
            // previous sample tracks the synced level every enabled cycle
            c_prev_next = c_sync;
            // shift in a one per enabled edge, saturates at all ones
            c_fill_next = {c_fill_reg[1:0], 1'b1};
        end
    end

    // previous-sample registers, empty after reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            c_prev_reg <= '0;
            c_fill_reg <= 3'h0;
        end else begin
            c_prev_reg <= c_prev_next;
            c_fill_reg <= c_fill_next;
        end
    end

    // event pulses: one per detected change, held while the enable is low
    always_comb begin
        hold_release_next = hold_release_reg;
        change_irq_next = change_irq_reg;
        if (clk_en) begin
            // unmasked pins never count; hold release needs no enable
            hold_release_next = c_primed && (|c_change);
            // the interrupt flag gates the request only, never the wake-up
            change_irq_next = c_primed && (|c_change)
                && port_c_change_irq_enable;
        end
    end

    // event registers, quiet after reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_release_reg <= 1'b0;
            change_irq_reg <= 1'b0;
        end else begin
            hold_release_reg <= hold_release_next;
            change_irq_reg <= change_irq_next;
        end
    end

    // input data capture for the core's port reads
    always_comb begin
        a_in_next = a_in_reg;
        b_in_next = b_in_reg;
        c_in_next = c_in_reg;
        if (clk_en) begin
            // one more flop after the synchroniser, so reads come from a register
            a_in_next = a_sync;
            b_in_next = b_sync;
            c_in_next = c_sync;
        end
    end

    // input data registers, zero until the first samples arrive
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            a_in_reg <= '0;
            b_in_reg <= '0;
            c_in_reg <= '0;
        end else begin
            a_in_reg <= a_in_next;
            b_in_reg <= b_in_next;
            c_in_reg <= c_in_next;
        end
    end

    // outputs straight from flops
    assign port_c_pullup_en = c_pullup_reg;
    assign port_d_pullup_en = d_pullup_reg;
    assign port_a_in_data = a_in_reg;
    assign port_b_in_data = b_in_reg;
    assign port_c_in_data = c_in_reg;
    assign hold_release = hold_release_reg;
    assign port_c_change_irq = change_irq_reg;
endmodule

// file: inc/pmw_pkg.sv
// constants and types shared by the port mode and wake configuration block
package pmw_pkg;
    // width of every port and configuration register
    localparam int PMW_W = 4;
    // register select codes on the immediate-load port
    typedef enum logic [1:0] {
        PMW_SEL_WAKE_MASK = 2'h0, // change_wake_mask
        PMW_SEL_DRIVE_PULL = 2'h1, // port_drive_pull_cfg
        PMW_SEL_A_DIR = 2'h2, // port_a_dir_cfg
        PMW_SEL_B_DIR = 2'h3 // port_b_dir_cfg
    } pmw_sel_t;
    // values after reset
    localparam logic [3:0] PMW_WAKE_MASK_RST = 4'h0;
    localparam logic [3:0] PMW_DRIVE_PULL_RST = 4'h0;
    localparam logic [3:0] PMW_A_DIR_RST = 4'hf;
    localparam logic [3:0] PMW_B_DIR_RST = 4'hf;
    // field positions in port_drive_pull_cfg
    localparam int PMW_DP_A_OPEN_DRAIN = 0;
    localparam int PMW_DP_B_OPEN_DRAIN = 1;
    localparam int PMW_DP_C_PULLUP = 2;
    localparam int PMW_DP_D_PULLUP = 3;
endpackage

// file: design/pmw_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pmw_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // first stage, read only by the second stage
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    initial begin
        if (WIDTH < 1) $error("pmw_sync: WIDTH must be at least 1");
    end

    // next values, frozen when the enable is low
    always_comb begin
        meta_next = meta_reg;
        sync_next = sync_reg;
        if (clk_en) begin
            meta_next = async_in;
            sync_next = meta_reg;
        end
    end

    // stage registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

// file: design/pmw_pin_drive.sv
// per-port pin driver: direction plus push-pull or open-drain output type
`timescale 1ns/1ps
module pmw_pin_drive #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] dir_in_mode,
    input wire logic open_drain,
    input wire logic [WIDTH-1:0] out_data,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_n
);
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;
    // enable is active low: 0 while the pin is driven
    logic [WIDTH-1:0] oe_n_reg;
    logic [WIDTH-1:0] oe_n_next;

    initial begin
        if (WIDTH < 1) $error("pmw_pin_drive: WIDTH must be at least 1");
    end

    // output level and enable per pin
    always_comb begin
        out_next = out_reg;
        oe_n_next = oe_n_reg;
        if (clk_en) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (dir_in_mode[i]) begin
                    // input pin: released
                    out_next[i] = 1'b0;
                    oe_n_next[i] = 1'b1;
                end else if (open_drain) begin
                    // n-channel only: pull low for 0, float for 1
                    out_next[i] = 1'b0;
                    oe_n_next[i] = out_data[i];
                end else begin
                    // complementary drive both ways
                    out_next[i] = out_data[i];
                    oe_n_next[i] = 1'b0;
                end
            end
        end
    end

    // registered so the pins come straight from flops; all released at reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_reg <= '0;
            oe_n_reg <= '1;
        end else begin
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign pin_out = out_reg;
    assign pin_oe_n = oe_n_reg;
endmodule

// file: tb/pmw_pin_model.sv
// far-side circuitry of one 4-bit port: external drivers and pull resistors
`timescale 1ns/1ps
module pmw_pin_model #(
    parameter bit EXT_PULL = 1'b0
) (
    input wire logic clk,
    input wire logic [3:0] drv,
    input wire logic [3:0] oe_n,
    input wire logic pull_en,
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_val,
    output logic [3:0] lvl
);
    // last resolved level, so an undriven line wanders instead of settling
    logic [3:0] last_q = 4'h0;
    // device drive wins, then far-side drivers, then pull resistors
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!oe_n[i]) begin
                lvl[i] = drv[i];
            end else if (ext_en[i]) begin
                lvl[i] = ext_val[i];
            end else if (pull_en || EXT_PULL) begin
                lvl[i] = 1'b1;
            end else begin
                lvl[i] = ~last_q[i]; // floating: no stable value
            end
        end
    end
    // remember the level for the floating pattern
    always @(posedge clk) begin
        last_q <= lvl;
    end
endmodule

// file: tb/pmw_port_cfg_properties.sv
// concurrent checks on the ports of the port mode and wake block
`timescale 1ns/1ps
module pmw_port_cfg_props
    import pmw_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic cfg_wr,
    input wire pmw_sel_t cfg_sel,
    input wire logic [3:0] cfg_data,
    input wire logic port_c_change_irq_enable,
    input wire logic [3:0] port_c_pin_in,
    input wire logic [3:0] port_a_pin_out,
    input wire logic [3:0] port_a_pin_oe_n,
    input wire logic [3:0] port_b_pin_oe_n,
    input wire logic port_c_pullup_en,
    input wire logic port_d_pullup_en,
    input wire logic hold_release,
    input wire logic port_c_change_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // shadows of the wake-mask and drive/pull write-only registers; dpd lags by the output stage
    logic [3:0] mask_reg, mask_next, dp_reg, dp_next, dpd_reg, dpd_next;
    // shadow next values
    always_comb begin
        mask_next = mask_reg;
        dp_next = dp_reg;
        dpd_next = clk_en ? dp_reg : dpd_reg;
        if (clk_en && cfg_wr && cfg_sel == PMW_SEL_WAKE_MASK) begin
            mask_next = cfg_data;
        end
        if (clk_en && cfg_wr && cfg_sel == PMW_SEL_DRIVE_PULL) begin
            dp_next = cfg_data;
        end
    end
    // shadow registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_reg <= 4'h0;
            dp_reg <= 4'h0;
            dpd_reg <= 4'h0;
        end else begin
            mask_reg <= mask_next;
            dp_reg <= dp_next;
            dpd_reg <= dpd_next;
        end
    end
    a_c_pullup_load: assert property (
        clk_en && cfg_wr && cfg_sel == PMW_SEL_DRIVE_PULL ##1 clk_en
        |-> ##1 port_c_pullup_en == $past(cfg_data[2], 2)) else $error("c pullup");
    a_d_pullup_load: assert property (
        clk_en && cfg_wr && cfg_sel == PMW_SEL_DRIVE_PULL ##1 clk_en
        |-> ##1 port_d_pullup_en == $past(cfg_data[3], 2)) else $error("d pullup");
    a_a_input_free: assert property (
        clk_en && cfg_wr && cfg_sel == PMW_SEL_A_DIR ##1 clk_en
        |-> ##1 (port_a_pin_oe_n & $past(cfg_data, 2)) == $past(cfg_data, 2))
        else $error("a input driven");
    a_b_input_free: assert property (
        clk_en && cfg_wr && cfg_sel == PMW_SEL_B_DIR ##1 clk_en
        |-> ##1 (port_b_pin_oe_n & $past(cfg_data, 2)) == $past(cfg_data, 2))
        else $error("b input driven");
    a_a_dir_reset: assert property ($rose(resetn) |-> port_a_pin_oe_n == 4'hf)
        else $error("a dir reset");
    a_b_dir_reset: assert property ($rose(resetn) |-> port_b_pin_oe_n == 4'hf)
        else $error("b dir reset");
    a_a_open_drain: assert property (
        dpd_reg[0] |-> (port_a_pin_out & ~port_a_pin_oe_n) == 4'h0) else $error("a drives high");
    a_wake_on_change: assert property (
        (clk_en && |((port_c_pin_in ^ $past(port_c_pin_in)) & mask_reg)) ##1 clk_en [*2]
        |-> ##1 hold_release) else $error("no wake");
    a_stable_quiet: assert property (
        (clk_en && $stable(port_c_pin_in)) [*4] |-> !hold_release) else $error("spurious wake");
    a_irq_gated: assert property (
        port_c_change_irq |-> hold_release && $past(port_c_change_irq_enable))
        else $error("irq ungated");
endmodule
bind pmw_port_cfg pmw_port_cfg_props u_props (.*);

// file: tb/pmw_port_cfg_tb_top.sv
// self-checking bench for the port mode and wake configuration block
`timescale 1ns/1ps
module pmw_port_cfg_tb_top
    import pmw_pkg::*;
;
    logic clk = 0, resetn = 0, clk_en = 1, cfg_wr = 0, irq_en = 0;
    pmw_sel_t cfg_sel = PMW_SEL_WAKE_MASK;
    logic [3:0] cfg_data = 4'h0, a_out = 4'h0, b_out = 4'h0, c_ext = 4'h0;
    logic [3:0] a_ext_en = 4'hf, a_ext_val = 4'h3, b_ext_en = 4'hf, b_ext_val = 4'h6;
    logic [3:0] c_ext_en = 4'hf; // far-side drivers, released per scenario
    logic [3:0] a_pin, b_pin, c_pin, a_po, a_oe_n, b_po, b_oe_n, a_in, b_in, c_in;
    logic c_pu, d_pu, hold_rel, c_irq;
    logic [3:0] dirs [4] = '{4'h0, 4'h6, 4'h9, 4'hf}; // direction patterns
    int n_errors = 0, num_checks = 0, n_hold, n_irq;
    pmw_port_cfg dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .cfg_wr(cfg_wr),
        .cfg_sel(cfg_sel), .cfg_data(cfg_data), .port_c_change_irq_enable(irq_en),
        .port_a_out_data(a_out), .port_b_out_data(b_out), .port_a_pin_in(a_pin),
        .port_b_pin_in(b_pin), .port_c_pin_in(c_pin), .port_a_pin_out(a_po),
        .port_a_pin_oe_n(a_oe_n), .port_b_pin_out(b_po), .port_b_pin_oe_n(b_oe_n),
        .port_c_pullup_en(c_pu), .port_d_pullup_en(d_pu), .port_a_in_data(a_in),
        .port_b_in_data(b_in), .port_c_in_data(c_in), .hold_release(hold_rel),
        .port_c_change_irq(c_irq));
    // port_a has an external pull-up; far-side drivers are set per scenario
    pmw_pin_model #(.EXT_PULL(1'b1)) u_a (.clk(clk), .drv(a_po), .oe_n(a_oe_n),
        .pull_en(1'b0), .ext_en(a_ext_en), .ext_val(a_ext_val), .lvl(a_pin));
    pmw_pin_model u_b (.clk(clk), .drv(b_po), .oe_n(b_oe_n), .pull_en(1'b0),
        .ext_en(b_ext_en), .ext_val(b_ext_val), .lvl(b_pin));
    pmw_pin_model u_c (.clk(clk), .drv(4'h0), .oe_n(4'hf), .pull_en(c_pu),
        .ext_en(c_ext_en), .ext_val(c_ext), .lvl(c_pin));
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // compare and count
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // immediate load, strobe held so back-to-back loads work
    task wr(input pmw_sel_t s, input logic [3:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_sel = s;
        cfg_data = d;
    endtask
    // drop the strobe and let cycles pass
    task idle(input int n);
        repeat (n) begin
            @(negedge clk);
            cfg_wr = 1'b0;
        end
    endtask
    // flip port_c pins, then count event pulses over a fixed window
    task flip(input logic [3:0] f);
        @(negedge clk);
        c_ext = c_ext ^ f;
        n_hold = 0;
        n_irq = 0;
        repeat (8) begin
            @(negedge clk);
            n_hold += (hold_rel === 1'b1);
            n_irq += (c_irq === 1'b1);
        end
    endtask
    // verdict and end of run
    task wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        idle(4);
        chk(a_oe_n, 4'hf);
        chk(b_oe_n, 4'hf);
        chk(a_in, 4'h3);
        chk(b_in, 4'h6);
        a_ext_en = 4'h0;
        a_out = 4'h5;
        b_out = 4'ha;
        // per-pin direction, port_b gets the complement
        for (int k = 0; k < 4; k++) begin
            wr(PMW_SEL_A_DIR, dirs[k]);
            wr(PMW_SEL_B_DIR, ~dirs[k]);
            idle(2);
            chk(a_oe_n, dirs[k]);
            chk(a_po & ~dirs[k], 4'h5 & ~dirs[k]);
            chk(b_oe_n, ~dirs[k]);
            chk(b_po & dirs[k], 4'ha & dirs[k]);
        end
        // open drain on both ports, all pins outputs
        wr(PMW_SEL_A_DIR, 4'h0);
        wr(PMW_SEL_B_DIR, 4'h0);
        wr(PMW_SEL_DRIVE_PULL, 4'h3);
        idle(2);
        chk(a_oe_n, 4'h5);
        chk(b_oe_n, 4'ha);
        idle(4);
        chk(a_in, 4'h5);
        wr(PMW_SEL_DRIVE_PULL, 4'h1);
        idle(2);
        chk(b_oe_n, 4'h0);
        chk(b_po, 4'ha);
        // every pull-up combination
        for (int i = 0; i < 4; i++) begin
            wr(PMW_SEL_DRIVE_PULL, 4'(i * 4));
            idle(2);
            chk({2'b00, d_pu, c_pu}, 4'(i));
        end
        // frozen clock enable ignores a load
        clk_en = 1'b0;
        wr(PMW_SEL_DRIVE_PULL, 4'h0);
        idle(2);
        clk_en = 1'b1;
        idle(2);
        chk({2'b00, d_pu, c_pu}, 4'h3);
        // release port_c from outside: the pull-ups must hold it high
        c_ext_en = 4'h0;
        idle(4);
        chk(c_in, 4'hf);
        c_ext_en = 4'hf;
        idle(4);
        // change detect per mask bit
        irq_en = 1'b1;
        for (int n = 0; n < 4; n++) begin
            wr(PMW_SEL_WAKE_MASK, 4'(1 << n));
            idle(3);
            flip(~4'(1 << n));
            chk(4'(n_hold), 4'h0);
            flip(4'(1 << n));
            chk(4'(n_hold), 4'h1);
            chk(4'(n_irq), 4'h1);
        end
        irq_en = 1'b0;
        flip(4'h8);
        chk(4'(n_hold), 4'h1);
        chk(4'(n_irq), 4'h0);
        chk(c_in, 4'h8);
        wr(PMW_SEL_WAKE_MASK, 4'h0);
        idle(3);
        flip(4'hf);
        chk(4'(n_hold), 4'h0);
        // second reset in mid-run
        resetn = 1'b0;
        idle(2);
        resetn = 1'b1;
        // port_c pins 0 to 2 idle high here, pin 3 low: an early mask must not see a false change
        wr(PMW_SEL_WAKE_MASK, 4'hf);
        flip(4'h0);
        chk(4'(n_hold), 4'h0);
        chk(a_oe_n, 4'hf);
        chk(b_oe_n, 4'hf);
        wrap_up;
    end
endmodule
